// [rtl/camera_digital_io_strobe.sv]
// camera digital input/output pin logic with apb registers and capture strobe
// How it works
// - an input polarity bit either passes the synchronised input as is or inverts it.
// - the status register shows the polarity-adjusted input level.
// - a two-bit source field picks user level, filter announce or strobe for output 0.
// - under the user source the output follows the software level bit, which is otherwise ignored.
// - under the announce source the output follows the infrared-cut filter position.
// - under the strobe source one pulse is emitted per capture start seen while idle; starts during a delay or pulse are dropped.
// - the pulse starts a programmable number of microseconds after capture start.
// - the pulse lasts a programmable number of microseconds, then the output is inactive.
// - an output polarity bit inverts the driven pin level.
// - until the boot-done bit is set the pin uses normal polarity.
// - the status register shows whether the output is active, whatever the source.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module camera_digital_io_strobe (
    // apb clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [cam_io_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // camera internals
    input  wire logic                          capture_start,
    input  wire logic                          filter_position_announce,
    // pins
    input  wire logic                          din_pin,
    output logic                               dout_pin
);
    import cam_io_pkg::*;

    default clocking cb_main @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ************************************************************
    // registers
    // ************************************************************
    io_ctrl_s    ctrl_reg;
    strobe_cfg_s cfg_reg;
    logic        din_meta_reg;
    logic        din_sync_reg;
    logic        in_active_reg;
    logic        out_active_reg;
    logic        tick;
    logic        strobe_pulse;
    logic        strobe_busy;
    logic        out_active_next;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : addr_hit

    wire logic access  = psel && penable;
    // writes land only at the edge that answers the transfer
    wire logic wr_en   = access && pwrite && pready;
    wire logic mapped  = addr_hit(paddr, CTRL_OFFSET) || addr_hit(paddr, STATUS_OFFSET) ||
                         addr_hit(paddr, DELAY_OFFSET) || addr_hit(paddr, DURATION_OFFSET);

    // ************************************************************
    // input path
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            din_meta_reg <= din_pin;
            din_sync_reg <= din_meta_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_active_reg <= 1'b0;
        end else begin
            in_active_reg <= din_sync_reg ^ ctrl_reg.in_invert;
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '{src: SRC_RESET, boot_done: 1'b0, user_level: 1'b0,
                          out_invert: 1'b0, in_invert: 1'b0};
        end else if (wr_en && addr_hit(paddr, CTRL_OFFSET) && pstrb[0]) begin
            ctrl_reg.in_invert  <= pwdata[CTRL_IN_INV_BIT];
            ctrl_reg.out_invert <= pwdata[CTRL_OUT_INV_BIT];
            ctrl_reg.user_level <= pwdata[CTRL_USER_LVL_BIT];
            ctrl_reg.boot_done  <= pwdata[CTRL_BOOT_DONE_BIT];
            ctrl_reg.src        <= out_src_e'(pwdata[CTRL_SRC_MSB:CTRL_SRC_LSB]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= '{delay_us: DELAY_RESET, duration_us: DURATION_RESET};
        end else if (wr_en) begin
            for (int b = 0; b < 2; b++) begin
                if (pstrb[b] && addr_hit(paddr, DELAY_OFFSET)) begin
                    cfg_reg.delay_us[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
                if (pstrb[b] && addr_hit(paddr, DURATION_OFFSET)) begin
                    cfg_reg.duration_us[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
            end
        end
    end

    // ************************************************************
    // read path and answer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // one wait state: answer is registered so outputs stay flop-driven
            pready  <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata  <= '0;
            if (access && !pready && !pwrite) begin
                case (paddr)
                    CTRL_OFFSET: begin
                        prdata[CTRL_IN_INV_BIT]              <= ctrl_reg.in_invert;
                        prdata[CTRL_OUT_INV_BIT]             <= ctrl_reg.out_invert;
                        prdata[CTRL_USER_LVL_BIT]            <= ctrl_reg.user_level;
                        prdata[CTRL_BOOT_DONE_BIT]           <= ctrl_reg.boot_done;
                        prdata[CTRL_SRC_MSB:CTRL_SRC_LSB]    <= ctrl_reg.src;
                    end
                    STATUS_OFFSET: begin
                        prdata[STAT_IN_BIT]     <= in_active_reg;
                        prdata[STAT_OUT_BIT]    <= out_active_reg;
                        prdata[STAT_STROBE_BIT] <= strobe_busy;
                    end
                    DELAY_OFFSET:    prdata[TIME_W-1:0] <= cfg_reg.delay_us;
                    DURATION_OFFSET: prdata[TIME_W-1:0] <= cfg_reg.duration_us;
                    default:         prdata <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // strobe timing
    // ************************************************************
    us_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    strobe_gen u_strobe (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        (ctrl_reg.src == SRC_STROBE),
        .tick          (tick),
        .capture_start (capture_start),
        .cfg           (cfg_reg),
        .pulse         (strobe_pulse),
        .busy          (strobe_busy)
    );

    // ************************************************************
    // output path
    // ************************************************************
    always_comb begin
        case (ctrl_reg.src)
            SRC_USER:     out_active_next = ctrl_reg.user_level;
            SRC_ANNOUNCE: out_active_next = filter_position_announce;
            SRC_STROBE:   out_active_next = strobe_pulse;
            default:      out_active_next = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_active_reg <= 1'b0;
            dout_pin       <= 1'b0;
        end else begin
            out_active_reg <= out_active_next;
            // inversion held off until software marks boot complete
            dout_pin <= out_active_next ^ (ctrl_reg.out_invert && ctrl_reg.boot_done);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_access_taken;
        psel && penable && !pready;
    endsequence

    property p_apb_one_wait;
        @(posedge pclk) disable iff (!presetn) s_access_taken |=> pready;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb answer not one cycle late");

    property p_in_polarity;
        @(posedge pclk) disable iff (!presetn)
            1'b1 |=> in_active_reg == ($past(din_sync_reg) ^ $past(ctrl_reg.in_invert));
    endproperty
    a_in_polarity: assert property (p_in_polarity) else $error("input status polarity wrong");

    property p_sync_two;
        @(posedge pclk) disable iff (!presetn) 1'b1 |=> ##1 din_sync_reg == $past(din_pin, 2);
    endproperty
    a_sync_two: assert property (p_sync_two) else $error("input not two-stage synchronised");

    property p_user_src;
        @(posedge pclk) disable iff (!presetn)
            (ctrl_reg.src == SRC_USER) |=> out_active_reg == $past(ctrl_reg.user_level);
    endproperty
    a_user_src: assert property (p_user_src) else $error("user level not driven");

    property p_announce_src;
        @(posedge pclk) disable iff (!presetn)
            (ctrl_reg.src == SRC_ANNOUNCE) |=> out_active_reg == $past(filter_position_announce);
    endproperty
    a_announce_src: assert property (p_announce_src) else $error("announce not driven");

    property p_boot_polarity;
        @(posedge pclk) disable iff (!presetn)
            !ctrl_reg.boot_done |=> dout_pin == out_active_reg;
    endproperty
    a_boot_polarity: assert property (p_boot_polarity) else $error("inverted before boot done");

    property p_out_polarity;
        @(posedge pclk) disable iff (!presetn)
            (ctrl_reg.boot_done && ctrl_reg.out_invert) |=> dout_pin != out_active_reg;
    endproperty
    a_out_polarity: assert property (p_out_polarity) else $error("output not inverted");

    property p_strobe_busy_ignore;
        @(posedge pclk) disable iff (!presetn)
            (strobe_busy && ctrl_reg.src == SRC_STROBE && !strobe_pulse) |=> strobe_busy;
    endproperty
    a_strobe_busy_ignore: assert property (p_strobe_busy_ignore) else $error("delay phase aborted");

    property p_non_strobe_quiet;
        @(posedge pclk) disable iff (!presetn) (ctrl_reg.src != SRC_STROBE) |=> !strobe_busy;
    endproperty
    a_non_strobe_quiet: assert property (p_non_strobe_quiet) else $error("strobe runs outside strobe source");

    sequence s_strobe_go;
        capture_start && !strobe_busy && ctrl_reg.src == SRC_STROBE;
    endsequence

    sequence s_short_pulse;
        strobe_pulse ##1 !strobe_pulse;
    endsequence

    property p_strobe_start;
        s_strobe_go |=> strobe_busy;
    endproperty
    a_strobe_start: assert property (p_strobe_start) else $error("capture start missed");

    property p_delay_wait;
        s_strobe_go ##0 (cfg_reg.delay_us != '0) |=> strobe_busy && !strobe_pulse;
    endproperty
    a_delay_wait: assert property (p_delay_wait) else $error("pulse before delay");

    property p_zero_delay;
        s_strobe_go ##0 (cfg_reg.delay_us == '0) |=> strobe_pulse;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay pulse late");

    property p_zero_width;
        s_strobe_go ##0 (cfg_reg.delay_us == '0 && cfg_reg.duration_us == '0) |=> s_short_pulse;
    endproperty
    a_zero_width: assert property (p_zero_width) else $error("zero width pulse wrong");

    property p_pulse_hold;
        strobe_pulse && $past(strobe_pulse) && !tick && ctrl_reg.src == SRC_STROBE |=> strobe_pulse;
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended without tick");

    property p_spare_off;
        (ctrl_reg.src == SRC_SPARE) |=> !out_active_reg;
    endproperty
    a_spare_off: assert property (p_spare_off) else $error("spare source drives output");

    property p_status_read;
        s_access_taken ##0 (!pwrite && paddr == STATUS_OFFSET) |=>
            prdata[STAT_IN_BIT] == $past(in_active_reg) && prdata[STAT_OUT_BIT] == $past(out_active_reg);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits wrong");

    property p_err_unmapped;
        s_access_taken ##0 !mapped |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

    property p_rdata_idle;
        !pready |-> prdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

endmodule : camera_digital_io_strobe
`default_nettype wire

// [rtl/cam_io_pkg.sv]
// package: register map, field layout, reset values and timing for the camera digital io block
package cam_io_pkg;

    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET     = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 12'h004;
    localparam logic [ADDR_W-1:0] DELAY_OFFSET    = 12'h008;
    localparam logic [ADDR_W-1:0] DURATION_OFFSET = 12'h00c;

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int CTRL_IN_INV_BIT   = 0;
    localparam int CTRL_OUT_INV_BIT  = 1;
    localparam int CTRL_USER_LVL_BIT = 2;
    localparam int CTRL_BOOT_DONE_BIT = 3;
    localparam int CTRL_SRC_LSB      = 4;
    localparam int CTRL_SRC_MSB      = 5;

    // ************************************************************
    // status field positions
    // ************************************************************
    localparam int STAT_IN_BIT     = 0;
    localparam int STAT_OUT_BIT    = 1;
    localparam int STAT_STROBE_BIT = 2;

    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam int TIME_W = 16;
    localparam logic [TIME_W-1:0] DELAY_RESET    = 16'h0000;
    localparam logic [TIME_W-1:0] DURATION_RESET = 16'h0001;
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_USER,
        SRC_ANNOUNCE,
        SRC_STROBE,
        SRC_SPARE
    } out_src_e;

    localparam out_src_e SRC_RESET = SRC_USER;

    typedef struct packed {
        out_src_e          src;
        logic              boot_done;
        logic              user_level;
        logic              out_invert;
        logic              in_invert;
    } io_ctrl_s;

    typedef struct packed {
        logic [TIME_W-1:0] delay_us;
        logic [TIME_W-1:0] duration_us;
    } strobe_cfg_s;

endpackage : cam_io_pkg

// [rtl/us_tick_gen.sv]
// microsecond tick generator derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module us_tick_gen #(
    parameter int CYCLES = cam_io_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // tick out
    output logic      tick
);
    import cam_io_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            tick <= (cnt_reg == LAST);
            if (cnt_reg == LAST) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end

endmodule : us_tick_gen
`default_nettype wire

// [rtl/strobe_gen.sv]
// capture-synchronised strobe pulse: delay then width, both counted in microsecond ticks
`timescale 1ns/1ps
`default_nettype none
module strobe_gen (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // control
    input  wire logic                     enable,
    input  wire logic                     tick,
    input  wire logic                     capture_start,
    input  wire cam_io_pkg::strobe_cfg_s  cfg,
    // outputs
    output logic                          pulse,
    output logic                          busy
);
    import cam_io_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} strobe_state_e;

    strobe_state_e     state_reg;
    logic [TIME_W-1:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else if (!enable) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (capture_start) begin
                        cnt_reg <= cfg.delay_us;
                        // zero delay goes straight to the pulse
                        state_reg <= (cfg.delay_us == '0) ? ST_PULSE : ST_DELAY;
                        if (cfg.delay_us == '0) begin
                            cnt_reg <= cfg.duration_us;
                        end
                    end
                end
                ST_DELAY: begin
                    if (tick) begin
                        if (cnt_reg <= TIME_W'(1)) begin
                            state_reg <= ST_PULSE;
                            cnt_reg   <= cfg.duration_us;
                        end else begin
                            cnt_reg <= cnt_reg - TIME_W'(1);
                        end
                    end
                end
                ST_PULSE: begin
                    if (cnt_reg == '0 || (tick && cnt_reg == TIME_W'(1))) begin
                        state_reg <= ST_IDLE;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg - TIME_W'(1);
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // capture starts seen outside idle are dropped
    assign busy  = (state_reg != ST_IDLE);
    assign pulse = (state_reg == ST_PULSE);

endmodule : strobe_gen
`default_nettype wire

// [tb/ext_pin_partner.sv]
// model of the external switch on the input pin and the lamp on the output pin
`timescale 1ns/1ps
`default_nettype none
module ext_pin_partner (
    // clock
    input  wire logic pclk,
    // switch command and lamp pin
    input  wire logic sw_level,
    input  wire logic dout_pin,
    output logic      din_pin,
    // lamp observations in clock cycles
    output int        cyc,
    output int        lamp_edges,
    output int        lamp_rise,
    output int        lamp_width
);
    logic last;
    int   run;
    initial begin
        din_pin = 1'b0;
        last = 1'b0;
        run = 0;
        cyc = 0;
        lamp_edges = 0;
        lamp_rise = 0;
        lamp_width = 0;
    end
    // switch level lands on a clock edge, asynchronous to nothing inside the camera's sync chain
    always @(posedge pclk) din_pin <= sw_level;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        last <= dout_pin;
        if (dout_pin && !last) begin
            lamp_edges <= lamp_edges + 1;
            lamp_rise <= cyc;
            run <= 1;
        end else if (dout_pin) begin
            run <= run + 1;
        end
        if (!dout_pin && last) lamp_width <= run;
    end
endmodule : ext_pin_partner
`default_nettype wire

// [tb/camera_digital_io_strobe_tb_top.sv]
// self-checking bench for the camera digital io and strobe block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("BAD %s exp %0h got %0h", nm, e, g); \
        end \
    end
module camera_digital_io_strobe_tb_top
    import cam_io_pkg::*;
();
    // ************************************************************
    // signals
    // ************************************************************
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [3:0]        pstrb = 4'hf;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              capture_start = 1'b0;
    logic              filter_position_announce = 1'b0;
    logic              din_pin;
    logic              dout_pin;
    logic              sw_level = 1'b0;
    int                cyc, lamp_edges, lamp_rise, lamp_width;
    int                num_errors = 0;
    int                n_checks = 0;
    int                tcount = 0;
    logic [31:0]       q;
    logic              e;

    always #2.5 pclk = ~pclk;

    camera_digital_io_strobe uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_start(capture_start),
        .filter_position_announce(filter_position_announce), .din_pin(din_pin), .dout_pin(dout_pin));
    ext_pin_partner far (.pclk(pclk), .sw_level(sw_level), .dout_pin(dout_pin), .din_pin(din_pin),
        .cyc(cyc), .lamp_edges(lamp_edges), .lamp_rise(lamp_rise), .lamp_width(lamp_width));

    // ************************************************************
    // bus and helper tasks
    // ************************************************************
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) `CHK("pready", 1'b1, pready)
    endtask : apb

    function automatic logic [31:0] ctrl(out_src_e s, logic bd, logic lv, logic oi, logic ii);
        io_ctrl_s c;
        c = '{src: s, boot_done: bd, user_level: lv, out_invert: oi, in_invert: ii};
        return {26'h0, c};
    endfunction : ctrl

    task automatic set_ctrl(input logic [31:0] v);
        apb(1'b1, CTRL_OFFSET, v);
        repeat (3) @(posedge pclk);
    endtask : set_ctrl

    task automatic rd_status();
        apb(1'b0, STATUS_OFFSET, 32'h0);
    endtask : rd_status

    task automatic cap();
        @(posedge pclk);
        capture_start <= 1'b1;
        @(posedge pclk);
        capture_start <= 1'b0;
    endtask : cap

    task automatic wait_dout(input logic lv);
        int n;
        n = 0;
        while (dout_pin !== lv && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) `CHK("dout_wait", lv, dout_pin)
    endtask : wait_dout

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        apb(1'b0, CTRL_OFFSET, 32'h0);
        `CHK("ctrl_rst", 32'h0, q)
        apb(1'b0, DELAY_OFFSET, 32'h0);
        `CHK("delay_rst", {16'h0, DELAY_RESET}, q)
        apb(1'b0, DURATION_OFFSET, 32'h0);
        `CHK("dur_rst", {16'h0, DURATION_RESET}, q)
        `CHK("mapped_ok", 1'b0, e)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, q)
        $display("test reset done");
    endtask : t_reset

    task automatic t_input();
        @(posedge pclk);
        sw_level <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_status();
        `CHK("in_normal_hi", 1'b1, q[STAT_IN_BIT])
        set_ctrl(ctrl(SRC_USER, 1'b0, 1'b0, 1'b0, 1'b1));
        rd_status();
        `CHK("in_inv_hi", 1'b0, q[STAT_IN_BIT])
        @(posedge pclk);
        sw_level <= 1'b0;
        @(posedge pclk);
        rd_status();
        `CHK("in_sync_lag", 1'b0, q[STAT_IN_BIT])
        repeat (4) @(posedge pclk);
        rd_status();
        `CHK("in_inv_lo", 1'b1, q[STAT_IN_BIT])
        $display("test input done");
    endtask : t_input

    task automatic t_user();
        int e0;
        set_ctrl(ctrl(SRC_USER, 1'b0, 1'b0, 1'b0, 1'b0));
        e0 = lamp_edges;
        cap();
        repeat (20) @(posedge pclk);
        `CHK("no_strobe_user", e0, lamp_edges)
        set_ctrl(ctrl(SRC_USER, 1'b0, 1'b1, 1'b0, 1'b0));
        `CHK("user_hi", 1'b1, dout_pin)
        set_ctrl(ctrl(SRC_USER, 1'b0, 1'b1, 1'b1, 1'b0));
        `CHK("boot_normal", 1'b1, dout_pin)
        set_ctrl(ctrl(SRC_USER, 1'b1, 1'b1, 1'b1, 1'b0));
        `CHK("out_inv_act", 1'b0, dout_pin)
        rd_status();
        `CHK("out_stat_inv", 1'b1, q[STAT_OUT_BIT])
        set_ctrl(ctrl(SRC_USER, 1'b1, 1'b0, 1'b1, 1'b0));
        `CHK("out_inv_idle", 1'b1, dout_pin)
        $display("test user done");
    endtask : t_user

    task automatic t_announce();
        set_ctrl(ctrl(SRC_ANNOUNCE, 1'b1, 1'b1, 1'b0, 1'b0));
        `CHK("ann_lo", 1'b0, dout_pin)
        @(posedge pclk);
        filter_position_announce <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("ann_hi", 1'b1, dout_pin)
        rd_status();
        `CHK("ann_stat", 1'b1, q[STAT_OUT_BIT])
        set_ctrl(ctrl(SRC_SPARE, 1'b1, 1'b1, 1'b0, 1'b0));
        `CHK("spare_off", 1'b0, dout_pin)
        $display("test announce done");
    endtask : t_announce

    task automatic t_strobe(input int dly, input int wid);
        int e0, t0, d;
        apb(1'b1, DELAY_OFFSET, dly);
        apb(1'b1, DURATION_OFFSET, wid);
        apb(1'b0, DELAY_OFFSET, 32'h0);
        `CHK("delay_rb", dly, q)
        set_ctrl(ctrl(SRC_STROBE, 1'b1, 1'b1, 1'b0, 1'b0));
        `CHK("strobe_idle", 1'b0, dout_pin)
        e0 = lamp_edges;
        @(posedge pclk);
        capture_start <= 1'b1;
        t0 = cyc;
        @(posedge pclk);
        capture_start <= 1'b0;
        if (dly > 0) begin
            repeat (20) @(posedge pclk);
            cap();
            wait_dout(1'b1);
            rd_status();
            `CHK("busy_mid", 1'b1, q[STAT_STROBE_BIT])
            `CHK("out_stat_strobe", 1'b1, q[STAT_OUT_BIT])
        end
        wait_dout(1'b0);
        repeat (4) @(posedge pclk);
        `CHK("one_pulse", e0 + 1, lamp_edges)
        d = lamp_rise - t0;
        `CHK("delay_ok", 1'b1, d >= (dly - 1) * TICK_CYCLES && d <= dly * TICK_CYCLES + 6)
        if (wid == 0) `CHK("width_min", 1, lamp_width)
        else `CHK("width_ok", 1'b1, lamp_width >= (wid-1)*TICK_CYCLES && lamp_width <= wid*TICK_CYCLES+2)
        rd_status();
        `CHK("busy_end", 1'b0, q[STAT_STROBE_BIT])
        $display("test strobe %0d %0d done", dly, wid);
    endtask : t_strobe

    // ************************************************************
    // main sequence and timeout
    // ************************************************************
    always @(posedge pclk) begin
        tcount++;
        if (tcount == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_input();
        t_user();
        t_announce();
        t_strobe(2, 3);
        t_strobe(0, 0);
        end_sim();
    end
endmodule : camera_digital_io_strobe_tb_top
`undef CHK
`default_nettype wire
